// ### rcf_event_irq.sv
// sticky event status with enable mask and write-one-to-clear
`timescale 1ns/1ps
module rcf_event_irq #(
    parameter int N = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic [N-1:0] event_i,
    input  wire logic         clr_wr_i,
    input  wire logic         en_wr_i,
    input  wire logic [N-1:0] wdata_i,
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] enable_o,
    output logic              irq_o
);
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] enable;
    } rcf_irq_type;

    rcf_irq_type st_reg;
    rcf_irq_type st_next;

    always_comb begin
        st_next = st_reg;
        if (clr_wr_i) begin
            st_next.status = st_reg.status & ~wdata_i;
        end
        // a new event beats a clear in the same cycle
        st_next.status = st_next.status | event_i;
        if (en_wr_i) begin
            st_next.enable = wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign status_o = st_reg.status;
    assign enable_o = st_reg.enable;
    assign irq_o    = |(st_reg.status & st_reg.enable);

endmodule : rcf_event_irq

// ### rcf_pkg.sv
// constants and types shared by the reset cause flag recorder
package rcf_pkg;

    // ==========================================================
    // register bus
    localparam int         ADDR_W        = 4;
    localparam int         DATA_W        = 8;
    localparam logic [3:0] STATUS_OFS    = 4'h0;
    localparam logic [3:0] PCON0_OFS     = 4'h1;
    localparam logic [3:0] PCON1_OFS     = 4'h2;
    localparam logic [3:0] IRQ_STAT_OFS  = 4'h3;
    localparam logic [3:0] IRQ_EN_OFS    = 4'h4;
    localparam logic [3:0] IRQ_CLR_OFS   = 4'h5;

    // ==========================================================
    // field positions
    localparam int STATUS_TO_BIT  = 4;
    localparam int STATUS_PD_BIT  = 3;
    localparam int PCON0_OVF_BIT  = 7;
    localparam int PCON0_UNF_BIT  = 6;
    localparam int PCON0_WDT_BIT  = 4;
    localparam int PCON0_CLR_BIT  = 3;
    localparam int PCON0_RI_BIT   = 2;
    localparam int PCON0_POR_BIT  = 1;
    localparam int PCON0_BOR_BIT  = 0;
    localparam int PCON1_MEMORY_VIOLATION_FLAG_BIT = 1;

    // ==========================================================
    // interrupt event positions
    localparam int NUM_EVENTS   = 8;
    localparam int EV_BROWNOUT  = 0;
    localparam int EV_WDT_RESET = 1;
    localparam int EV_WDT_WAKE  = 2;
    localparam int EV_INT_WAKE  = 3;
    localparam int EV_EXT_CLEAR = 4;
    localparam int EV_RESET_INS = 5;
    localparam int EV_STACK     = 6;
    localparam int EV_MEM_VIOL  = 7;

    // ==========================================================
    // stack and flag state
    localparam int STACK_LEVELS = 16;

    typedef struct packed {
        logic stack_overflow_flag;
        logic stack_underflow_flag;
        logic watchdog_reset_flag;
        logic ext_clear_reset_flag;
        logic reset_instr_flag;
        logic power_on_flag;
        logic brownout_flag;
        logic timeout_flag;
        logic power_down_flag;
        logic memory_violation_flag;
    } rcf_flags_type;

    // power-on values; brownout flag is undefined there, held at 0
    localparam rcf_flags_type FLAGS_POR = 10'h0e7;

endpackage : rcf_pkg

// ### rcf_recorder.sv
// reset cause flag recorder with stack fault reset and register port
//
// Functional notes
// (R1) every reset source updates cause flags so software can identify it
// (R2) push past level sixteen with stack reset enabled resets and sets overflow
// (R3) pop below level one with stack reset enabled resets and sets underflow
// (R4) power-on and brown-out load their fixed flag patterns
// (R5) timeout flag reads 1 after power-on reset
// (R6) power-down flag reads 1 after power-on reset
// (R7) watchdog reset clears watchdog and timeout; watchdog wake clears timeout, power-down
// (R8) interrupt wake sets timeout, clears power-down, others kept
// (R9) external clear while running clears its flag, sets memory violation flag
// (R10) external clear in sleep clears its flag, sets timeout, clears power-down
// (R11) stack faults set, reset instruction and memory violation clear own flag
// (R12) flags stay until another reset or wake event or a software write
`timescale 1ns/1ps
module rcf_recorder
    import rcf_pkg::*;
#(
    parameter int LEVELS = rcf_pkg::STACK_LEVELS
) (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    input  wire logic [rcf_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [rcf_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [rcf_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                      stack_reset_enable_i,
    input  wire logic                      push_i,
    input  wire logic                      pop_i,
    input  wire logic                      brownout_i,
    input  wire logic                      wdt_timeout_i,
    input  wire logic                      wdt_wake_i,
    input  wire logic                      int_wake_i,
    input  wire logic                      ext_clear_i,
    input  wire logic                      sleeping_i,
    input  wire logic                      reset_instr_i,
    input  wire logic                      mem_violation_i,
    output logic                           core_reset_o,
    output logic                           timeout_flag_o,
    output logic                           power_down_flag_o,
    output logic                           irq_o
);
    import rcf_pkg::*;

    localparam int DW = $clog2(LEVELS + 1);

    typedef struct packed {
        rcf_flags_type       flags;
        logic                core_reset;
        logic [DATA_W-1:0]   rdata;
    } rcf_state_type;

    rcf_state_type st_reg;
    rcf_state_type st_next;

    logic [DW-1:0]         depth;
    logic                  ovf_seen;
    logic                  unf_seen;
    logic                  ovf_rst;
    logic                  unf_rst;
    logic [NUM_EVENTS-1:0] events;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_enable;
    logic                  any_reset;

    // ==========================================================
    // stack guard
    rcf_stack_guard #(
        .LEVELS (LEVELS),
        .DW     (DW)
    ) u_stack (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .push_i      (push_i),
        .pop_i       (pop_i),
        .clear_i     (st_reg.core_reset),
        .depth_o     (depth),
        .overflow_o  (ovf_seen),
        .underflow_o (unf_seen)
    );

    // (R2) gated overflow reset
    assign ovf_rst = ovf_seen && stack_reset_enable_i;
    // (R3) gated underflow reset
    assign unf_rst = unf_seen && stack_reset_enable_i;

    // (R1) any reset source resets the core; the two wake sources do not
    assign any_reset = brownout_i || wdt_timeout_i || ext_clear_i || reset_instr_i
                     || mem_violation_i || ovf_rst || unf_rst;

    // ==========================================================
    // event interrupts
    always_comb begin
        events               = '0;
        events[EV_BROWNOUT]  = brownout_i;
        events[EV_WDT_RESET] = wdt_timeout_i;
        events[EV_WDT_WAKE]  = wdt_wake_i;
        events[EV_INT_WAKE]  = int_wake_i;
        events[EV_EXT_CLEAR] = ext_clear_i;
        events[EV_RESET_INS] = reset_instr_i;
        events[EV_STACK]     = ovf_rst || unf_rst;
        events[EV_MEM_VIOL]  = mem_violation_i;
    end

    rcf_event_irq #(
        .N (NUM_EVENTS)
    ) u_irq (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .event_i  (events),
        .clr_wr_i (wr_i && (addr_i == IRQ_CLR_OFS)),
        .en_wr_i  (wr_i && (addr_i == IRQ_EN_OFS)),
        .wdata_i  (wdata_i),
        .status_o (irq_status),
        .enable_o (irq_enable),
        .irq_o    (irq_o)
    );

    // ==========================================================
    // flag update, register port
    always_comb begin
        // (R12) flags sticky by default
        st_next            = st_reg;
        st_next.core_reset = any_reset;
        st_next.rdata      = '0;

        // software write first so any hardware event this cycle wins
        if (wr_i) begin
            if (addr_i == PCON0_OFS) begin
                st_next.flags.stack_overflow_flag  = wdata_i[PCON0_OVF_BIT];
                st_next.flags.stack_underflow_flag = wdata_i[PCON0_UNF_BIT];
                st_next.flags.watchdog_reset_flag  = wdata_i[PCON0_WDT_BIT];
                st_next.flags.ext_clear_reset_flag = wdata_i[PCON0_CLR_BIT];
                st_next.flags.reset_instr_flag     = wdata_i[PCON0_RI_BIT];
                st_next.flags.power_on_flag        = wdata_i[PCON0_POR_BIT];
                st_next.flags.brownout_flag        = wdata_i[PCON0_BOR_BIT];
            end else if (addr_i == PCON1_OFS) begin
                st_next.flags.memory_violation_flag = wdata_i[PCON1_MEMORY_VIOLATION_FLAG_BIT];
            end
        end

        // (R11) single-flag sources
        if (reset_instr_i) begin
            st_next.flags.reset_instr_flag = 1'b0;
        end
        if (mem_violation_i) begin
            st_next.flags.memory_violation_flag = 1'b0;
        end
        // (R2) overflow flag set
        if (ovf_rst) begin
            st_next.flags.stack_overflow_flag = 1'b1;
        end
        // (R3) underflow flag set
        if (unf_rst) begin
            st_next.flags.stack_underflow_flag = 1'b1;
        end
        // (R7) watchdog reset and wake
        if (wdt_timeout_i) begin
            st_next.flags.watchdog_reset_flag = 1'b0;
            st_next.flags.timeout_flag        = 1'b0;
        end
        if (wdt_wake_i) begin
            st_next.flags.timeout_flag    = 1'b0;
            st_next.flags.power_down_flag = 1'b0;
        end
        // (R8) interrupt wake
        if (int_wake_i) begin
            st_next.flags.timeout_flag    = 1'b1;
            st_next.flags.power_down_flag = 1'b0;
        end
        if (ext_clear_i) begin
            st_next.flags.ext_clear_reset_flag = 1'b0;
            if (sleeping_i) begin
                // (R10) external clear in sleep
                st_next.flags.timeout_flag    = 1'b1;
                st_next.flags.power_down_flag = 1'b0;
            end else begin
                // (R9) external clear while running
                st_next.flags.memory_violation_flag = 1'b1;
            end
        end
        // (R4) brown-out pattern dominates everything else
        if (brownout_i) begin
            st_next.flags.stack_overflow_flag  = 1'b0;
            st_next.flags.stack_underflow_flag = 1'b0;
            st_next.flags.ext_clear_reset_flag = 1'b1;
            st_next.flags.reset_instr_flag     = 1'b1;
            st_next.flags.brownout_flag        = 1'b0;
            st_next.flags.timeout_flag         = 1'b1;
            st_next.flags.power_down_flag      = 1'b1;
        end

        // read data stand one cycle after the strobe only
        if (rd_i) begin
            if (addr_i == STATUS_OFS) begin
                st_next.rdata[STATUS_TO_BIT] = st_reg.flags.timeout_flag;
                st_next.rdata[STATUS_PD_BIT] = st_reg.flags.power_down_flag;
            end else if (addr_i == PCON0_OFS) begin
                st_next.rdata[PCON0_OVF_BIT] = st_reg.flags.stack_overflow_flag;
                st_next.rdata[PCON0_UNF_BIT] = st_reg.flags.stack_underflow_flag;
                st_next.rdata[PCON0_WDT_BIT] = st_reg.flags.watchdog_reset_flag;
                st_next.rdata[PCON0_CLR_BIT] = st_reg.flags.ext_clear_reset_flag;
                st_next.rdata[PCON0_RI_BIT]  = st_reg.flags.reset_instr_flag;
                st_next.rdata[PCON0_POR_BIT] = st_reg.flags.power_on_flag;
                st_next.rdata[PCON0_BOR_BIT] = st_reg.flags.brownout_flag;
            end else if (addr_i == PCON1_OFS) begin
                st_next.rdata[PCON1_MEMORY_VIOLATION_FLAG_BIT] = st_reg.flags.memory_violation_flag;
            end else if (addr_i == IRQ_STAT_OFS) begin
                st_next.rdata = irq_status;
            end else if (addr_i == IRQ_EN_OFS) begin
                st_next.rdata = irq_enable;
            end
        end
    end

    // (R4) (R5) (R6) power-on pattern is the reset value
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg       <= '0;
            st_reg.flags <= FLAGS_POR;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o           = st_reg.rdata;
    assign core_reset_o      = st_reg.core_reset;
    assign timeout_flag_o    = st_reg.flags.timeout_flag;
    assign power_down_flag_o = st_reg.flags.power_down_flag;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    logic quiet;
    assign quiet = !any_reset && !wdt_wake_i && !int_wake_i && !wr_i;

    sequence full_push_s;
        push_i && !pop_i && !st_reg.core_reset && (depth == DW'(LEVELS));
    endsequence

    sequence empty_pop_s;
        pop_i && !push_i && !st_reg.core_reset && (depth == '0);
    endsequence

    sequence calm_s;
        // enable counts in the cycle the fault is seen, not the push cycle
        !brownout_i && !wr_i && stack_reset_enable_i;
    endsequence

    // (R2) overflow reset
    stack_ovf_reset_a: assert property (full_push_s ##1 calm_s |=> // R2
        st_reg.flags.stack_overflow_flag && core_reset_o)
        else $error("overflow did not reset and flag");

    // (R3) underflow reset
    stack_unf_reset_a: assert property (empty_pop_s ##1 calm_s |=> // R3
        st_reg.flags.stack_underflow_flag && core_reset_o)
        else $error("underflow did not reset and flag");

    // (R1) reset pulse follows source
    reset_pulse_a: assert property (any_reset |=> core_reset_o ##1 (core_reset_o == $past(any_reset))) // R1
        else $error("core reset pulse wrong");

    // (R4) brown-out pattern
    brownout_pattern_a: assert property (brownout_i |=> !st_reg.flags.brownout_flag // R4
        && !st_reg.flags.stack_overflow_flag && !st_reg.flags.stack_underflow_flag
        && timeout_flag_o && power_down_flag_o)
        else $error("brown-out pattern wrong");

    // (R5) timeout after power-on
    por_timeout_a: assert property (@(posedge mclk_i) $rose(rst_n_i) |-> timeout_flag_o) // R5
        else $error("timeout flag low after power-on");

    // (R6) power-down after power-on
    por_powerdown_a: assert property (@(posedge mclk_i) $rose(rst_n_i) |-> power_down_flag_o) // R6
        else $error("power-down flag low after power-on");

    // (R7) watchdog timeout
    wdt_reset_flags_a: assert property (wdt_timeout_i && !brownout_i && !int_wake_i && !ext_clear_i // R7
        |=> !st_reg.flags.watchdog_reset_flag && !timeout_flag_o)
        else $error("watchdog reset flags wrong");

    // (R8) interrupt wake
    int_wake_flags_a: assert property (int_wake_i && !brownout_i && !ext_clear_i // R8
        |=> timeout_flag_o && !power_down_flag_o)
        else $error("interrupt wake flags wrong");

    // (R9) external clear running
    clear_run_a: assert property (ext_clear_i && !sleeping_i && !brownout_i // R9
        |=> !st_reg.flags.ext_clear_reset_flag && st_reg.flags.memory_violation_flag)
        else $error("external clear while running wrong");

    // (R10) external clear sleeping
    clear_sleep_a: assert property (ext_clear_i && sleeping_i && !brownout_i // R10
        |=> !st_reg.flags.ext_clear_reset_flag && timeout_flag_o && !power_down_flag_o)
        else $error("external clear in sleep wrong");

    // (R11) reset instruction
    reset_instr_a: assert property (reset_instr_i && !brownout_i |=> !st_reg.flags.reset_instr_flag) // R11
        else $error("reset instruction flag not cleared");

    // (R12) flags hold while quiet
    flags_sticky_a: assert property (quiet && !ovf_seen && !unf_seen [*2] |=> $stable(st_reg.flags)) // R12
        else $error("cause flag changed with no event");

endmodule : rcf_recorder

// ### rcf_stack_guard.sv
// stack depth tracker that flags pushes past the top and pops past the bottom
`timescale 1ns/1ps
module rcf_stack_guard #(
    parameter int LEVELS = 16,
    parameter int DW     = $clog2(LEVELS + 1)
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          push_i,
    input  wire logic          pop_i,
    input  wire logic          clear_i,
    output logic      [DW-1:0] depth_o,
    output logic               overflow_o,
    output logic               underflow_o
);
    typedef struct packed {
        logic [DW-1:0] depth;
        logic          ovf;
        logic          unf;
    } rcf_guard_type;

    rcf_guard_type st_reg;
    rcf_guard_type st_next;

    localparam logic [DW-1:0] FULL = DW'(LEVELS);

    always_comb begin
        st_next     = st_reg;
        st_next.ovf = 1'b0;
        st_next.unf = 1'b0;
        // push and pop together leave the depth as it is
        if (clear_i) begin
            st_next.depth = '0;
        end else if (push_i && !pop_i) begin
            if (st_reg.depth == FULL) begin
                st_next.ovf = 1'b1;
            end else begin
                st_next.depth = st_reg.depth + 1'b1;
            end
        end else if (pop_i && !push_i) begin
            if (st_reg.depth == '0) begin
                st_next.unf = 1'b1;
            end else begin
                st_next.depth = st_reg.depth - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign depth_o     = st_reg.depth;
    assign overflow_o  = st_reg.ovf;
    assign underflow_o = st_reg.unf;

endmodule : rcf_stack_guard

// ### rcf_tb.sv
// self-checking testbench for the reset cause flag recorder
`timescale 1ns/1ps
module tb;
    import rcf_pkg::*;

    // ==========================================================
    // signals
    logic                mclk_i;
    logic                rst_n_i;
    logic [ADDR_W-1:0]   addr_i;
    logic [DATA_W-1:0]   wdata_i;
    logic                wr_i;
    logic                rd_i;
    logic [DATA_W-1:0]   rdata_o;
    logic                sre;
    logic                push;
    logic                pop;
    logic                slp;
    logic [7:0]          ev;
    logic                core_reset_o;
    logic                timeout_flag_o;
    logic                power_down_flag_o;
    logic                irq_o;
    logic [7:0]          exp_p0;
    logic [7:0]          exp_p1;
    logic                exp_to;
    logic                exp_pd;
    logic [7:0]          rd_val;
    int                  n_mismatch;
    int                  tests_run;
    int                  cycles;

    localparam int LEVELS_TB = STACK_LEVELS;

    rcf_recorder i_dut (
        .mclk_i               (mclk_i),
        .rst_n_i              (rst_n_i),
        .addr_i               (addr_i),
        .wdata_i              (wdata_i),
        .wr_i                 (wr_i),
        .rd_i                 (rd_i),
        .rdata_o              (rdata_o),
        .stack_reset_enable_i (sre),
        .push_i               (push),
        .pop_i                (pop),
        .brownout_i           (ev[0]),
        .wdt_timeout_i        (ev[1]),
        .wdt_wake_i           (ev[2]),
        .int_wake_i           (ev[3]),
        .ext_clear_i          (ev[4]),
        .sleeping_i           (slp),
        .reset_instr_i        (ev[5]),
        .mem_violation_i      (ev[6]),
        .core_reset_o         (core_reset_o),
        .timeout_flag_o       (timeout_flag_o),
        .power_down_flag_o    (power_down_flag_o),
        .irq_o                (irq_o)
    );

    // ==========================================================
    // clock, timeout, closing
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // generous ceiling, the whole run needs under two hundred cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
        #1;
    endtask : bus_write

    // read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask : bus_read

    task automatic check_regs();
        bus_read(STATUS_OFS, rd_val);
        check(rd_val, {3'h0, exp_to, exp_pd, 3'h0});
        bus_read(PCON0_OFS, rd_val);
        check(rd_val, exp_p0);
        bus_read(PCON1_OFS, rd_val);
        check(rd_val, exp_p1);
        check({7'h0, timeout_flag_o}, {7'h0, exp_to});
        check({7'h0, power_down_flag_o}, {7'h0, exp_pd});
    endtask : check_regs

    // one event pulse; core reset pulses one cycle, wakes give none
    task automatic fire(input int kind, input logic s, input logic exp_rst);
        @(posedge mclk_i);
        ev  <= 8'h01 << kind;
        slp <= s;
        @(posedge mclk_i);
        ev  <= 8'h00;
        slp <= 1'b0;
        #1;
        check({7'h0, core_reset_o}, {7'h0, exp_rst});
        @(posedge mclk_i);
        #1;
        check({7'h0, core_reset_o}, 8'h00);
    endtask : fire

    // ==========================================================
    // scenarios
    task automatic s_writes();
        bus_write(PCON0_OFS, 8'hdf);
        bus_write(PCON1_OFS, 8'h00);
        // status is read-only, write ignored
        bus_write(STATUS_OFS, 8'h00);
        exp_p0 = 8'hdf;
        exp_p1 = 8'h00;
        repeat (5) @(posedge mclk_i);
        check_regs();
    endtask : s_writes

    task automatic s_wake_chain();
        fire(1, 1'b0, 1'b1);
        exp_p0[PCON0_WDT_BIT] = 1'b0;
        exp_to = 1'b0;
        check_regs();
        fire(0, 1'b0, 1'b1);
        exp_p0 = exp_p0 & 8'h3e | 8'h0c;
        exp_to = 1'b1;
        exp_pd = 1'b1;
        check_regs();
        fire(2, 1'b0, 1'b0);
        exp_to = 1'b0;
        exp_pd = 1'b0;
        check_regs();
        fire(3, 1'b0, 1'b0);
        exp_to = 1'b1;
        check_regs();
        fire(0, 1'b0, 1'b1);
        exp_pd = 1'b1;
        check_regs();
    endtask : s_wake_chain

    task automatic s_resets();
        fire(5, 1'b0, 1'b1);
        exp_p0[PCON0_RI_BIT] = 1'b0;
        check_regs();
        fire(4, 1'b1, 1'b1);
        exp_p0[PCON0_CLR_BIT] = 1'b0;
        exp_pd = 1'b0;
        check_regs();
        bus_write(PCON0_OFS, 8'h08);
        fire(4, 1'b0, 1'b1);
        exp_p0 = 8'h00;
        exp_p1[PCON1_MEMORY_VIOLATION_FLAG_BIT] = 1'b1;
        check_regs();
        fire(6, 1'b0, 1'b1);
        exp_p1[PCON1_MEMORY_VIOLATION_FLAG_BIT] = 1'b0;
        check_regs();
    endtask : s_resets

    // last strobe sampled at the release edge, fault seen one cycle on, core reset the cycle after
    task automatic stack_op(input int n_push, input logic do_pop, input logic exp_rst);
        for (int i = 0; i < n_push; i++) begin
            @(posedge mclk_i);
            push <= 1'b1;
        end
        if (do_pop) begin
            @(posedge mclk_i);
            pop <= 1'b1;
        end
        @(posedge mclk_i);
        push <= 1'b0;
        pop  <= 1'b0;
        @(posedge mclk_i);
        #1;
        check({7'h0, core_reset_o}, {7'h0, exp_rst});
    endtask : stack_op

    task automatic s_stack();
        sre <= 1'b0;
        stack_op(0, 1'b1, 1'b0);
        check_regs();
        sre <= 1'b1;
        stack_op(LEVELS_TB + 1, 1'b0, 1'b1);
        exp_p0[PCON0_OVF_BIT] = 1'b1;
        check_regs();
        stack_op(0, 1'b1, 1'b1);
        exp_p0[PCON0_UNF_BIT] = 1'b1;
        check_regs();
    endtask : s_stack

    task automatic s_irq();
        bus_write(IRQ_EN_OFS, 8'h00);
        bus_write(IRQ_CLR_OFS, 8'hff);
        bus_read(IRQ_STAT_OFS, rd_val);
        check(rd_val, 8'h00);
        fire(5, 1'b0, 1'b1);
        bus_read(IRQ_STAT_OFS, rd_val);
        check(rd_val, 8'h20);
        check({7'h0, irq_o}, 8'h00);
        bus_write(IRQ_EN_OFS, 8'h20);
        check({7'h0, irq_o}, 8'h01);
        bus_read(IRQ_EN_OFS, rd_val);
        check(rd_val, 8'h20);
        bus_write(IRQ_CLR_OFS, 8'h20);
        check({7'h0, irq_o}, 8'h00);
        bus_read(IRQ_CLR_OFS, rd_val);
        check(rd_val, 8'h00);
        bus_write(4'hf, 8'hff);
        bus_read(4'hf, rd_val);
        check(rd_val, 8'h00);
    endtask : s_irq

    // ==========================================================
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        sre = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        slp = 1'b0;
        ev = 8'h00;
        n_mismatch = 0;
        tests_run = 0;
        cycles = 0;
        exp_p0 = 8'h1c;
        exp_p1 = 8'h02;
        exp_to = 1'b1;
        exp_pd = 1'b1;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        check_regs();
        s_writes();
        s_wake_chain();
        s_resets();
        s_stack();
        s_irq();
        report_and_stop();
    end

endmodule : tb
